// ### rtl/ssr_router.sv
// servo status output router: registers, qualification and three output pairs
// assumes status inputs synchronous to CLK; software writes via a plain strobe port
//
// Function
// R1: nibble 0 off, 1..3 select pair
// R2: software never writes codes 4 to 6
// R3: signals sharing a pair are ORed
// R4: signal not evaluated in mode reads OFF
// R5: polarity nibble per pair, 1 inverts
// R6: route A: done, match, motion, ready
// R7: route B: torque, speed, brake, warning
// R8: near in C nibble 0; maintenance D nibble 1
// R9: fault output ON normally, OFF on error
// R10: warning ON while warning condition exists
// R11: motion ON when speed at/above level
// R12: rotary level 1..10000, default 20, immediate
// R13: linear level 1..10000, default 20, immediate
// R14: invert after OR, update next clock
`timescale 1ns/10ps
module ssr_router #(
    parameter int SPEED_W = 16
) (
    input  wire logic               CLK,             // 250 MHz drive clock
    input  wire logic               NRST,            // synchronous reset, low active
    input  wire logic [15:0]        ADDR,            // register address
    input  wire logic [15:0]        WDATA,           // write data
    input  wire logic               WR,              // write strobe
    input  wire logic               RD,              // read strobe
    output      logic [15:0]        RDATA,           // read data, cycle after RD
    input  wire ssr_pkg::ssr_mode_t MODE,            // current control mode
    input  wire logic               LINEAR_MOTOR,    // linear motor fitted
    input  wire logic [SPEED_W-1:0] SPEED,           // motor speed magnitude
    input  wire logic               POS_DONE,        // positioning complete
    input  wire logic               SPEED_MATCH,     // speed coincidence
    input  wire logic               SERVO_READY,     // ready for servo on
    input  wire logic               TORQUE_LIMITED,  // torque limit active
    input  wire logic               SPEED_LIMITED,   // speed limit active
    input  wire logic               BRAKE_RELEASE,   // brake release request
    input  wire logic               WARNING,         // warning condition
    input  wire logic               NEAR_POS,        // near position
    input  wire logic               MAINT_DUE,       // maintenance due
    input  wire logic               ERROR,           // error detected
    output      logic [2:0]         PAIR_OUT,        // terminal pairs 1..3, 1 = closed
    output      logic               FAULT_OUT,       // fault output, 1 = closed
    output      logic               MOTION_DETECT    // raw motion detection state
);
    import ssr_pkg::*;

    localparam int N = NUM_SIGNALS;

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] rotary_motion_detect_level;
    logic [15:0] linear_motion_detect_level;
    logic [15:0] output_route_select_a;
    logic [15:0] output_route_select_b;
    logic [15:0] output_route_select_c;
    logic [15:0] output_route_select_d;
    logic [15:0] output_pair_polarity;
    logic        next_motion;

    function automatic logic [15:0] clamp_level(input logic [15:0] v);
        if (v < LEVEL_MIN) begin
            clamp_level = LEVEL_MIN;
        end else if (v > LEVEL_MAX) begin
            clamp_level = LEVEL_MAX;
        end else begin
            clamp_level = v;
        end
    endfunction : clamp_level

    function automatic logic [3:0] nib(input logic [15:0] r, input int k);
        nib = r[4*k +: 4];
    endfunction : nib

    wire sel_rot  = (ADDR == OFS_ROTARY_LEVEL);
    wire sel_lin  = (ADDR == OFS_LINEAR_LEVEL);
    wire sel_ra   = (ADDR == OFS_ROUTE_A);
    wire sel_rb   = (ADDR == OFS_ROUTE_B);
    wire sel_rc   = (ADDR == OFS_ROUTE_C);
    wire sel_rd   = (ADDR == OFS_ROUTE_D);
    wire sel_pol  = (ADDR == OFS_POLARITY);
    wire sel_stat = (ADDR == OFS_STATUS);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rotary_motion_detect_level <= RST_LEVEL;     // see R12
            linear_motion_detect_level <= RST_LEVEL;     // see R13
            output_route_select_a      <= RST_ROUTE;
            output_route_select_b      <= RST_ROUTE;
            output_route_select_c      <= RST_ROUTE;
            output_route_select_d      <= RST_ROUTE;
            output_pair_polarity       <= RST_POLARITY;
        end else if (WR) begin
            // out-of-range level written is clamped, keeps detection defined
            if (sel_rot) rotary_motion_detect_level <= clamp_level(WDATA);   // see R12
            if (sel_lin) linear_motion_detect_level <= clamp_level(WDATA);   // see R13
            if (sel_ra)  output_route_select_a      <= WDATA;                // see R6
            if (sel_rb)  output_route_select_b      <= WDATA;                // see R7
            if (sel_rc)  output_route_select_c      <= WDATA;                // see R8
            if (sel_rd)  output_route_select_d      <= WDATA;                // see R8
            if (sel_pol) output_pair_polarity       <= {4'h0, WDATA[11:0]};  // see R5
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [15:0] read_mux;
    assign read_mux = sel_rot  ? rotary_motion_detect_level :
                      sel_lin  ? linear_motion_detect_level :
                      sel_ra   ? output_route_select_a :
                      sel_rb   ? output_route_select_b :
                      sel_rc   ? output_route_select_c :
                      sel_rd   ? output_route_select_d :
                      sel_pol  ? output_pair_polarity :
                      sel_stat ? {10'h000, MOTION_DETECT, FAULT_OUT, 1'b0, PAIR_OUT} :
                      16'h0000;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 16'h0000;
        end else begin
            RDATA <= RD ? read_mux : 16'h0000;
        end
    end

    // ************************************************************
    // motion detection
    // ************************************************************
    ssr_speed_detect #(
        .W (SPEED_W)
    ) u_speed (
        .speed        (SPEED),
        .rotary_level (rotary_motion_detect_level[SPEED_W-1:0]),
        .linear_level (linear_motion_detect_level[SPEED_W-1:0]),
        .linear       (LINEAR_MOTOR),
        .moving       (next_motion)
    );

    // ************************************************************
    // qualification by control mode
    // ************************************************************
    // signals without meaning in the present mode are forced off
    logic pos_ok;
    logic spd_ok;
    assign pos_ok = (MODE == MODE_POSITION);   // see R4
    assign spd_ok = (MODE == MODE_SPEED);      // see R4

    logic [N-1:0]   sig;
    logic [4*N-1:0] route;

    assign sig = {MAINT_DUE,
                  NEAR_POS & pos_ok,
                  WARNING,                       // see R10
                  BRAKE_RELEASE,
                  SPEED_LIMITED,
                  TORQUE_LIMITED,
                  SERVO_READY,
                  next_motion,                   // see R11
                  SPEED_MATCH & spd_ok,          // see R4
                  POS_DONE & pos_ok};            // see R4

    assign route = {nib(output_route_select_d, NIB_MAINT),       // see R8
                    nib(output_route_select_c, NIB_NEAR),        // see R8
                    nib(output_route_select_b, NIB_WARNING),     // see R7
                    nib(output_route_select_b, NIB_BRAKE),
                    nib(output_route_select_b, NIB_SPEED_LIM),
                    nib(output_route_select_b, NIB_TORQUE_LIM),
                    nib(output_route_select_a, NIB_READY),       // see R6
                    nib(output_route_select_a, NIB_MOTION),
                    nib(output_route_select_a, NIB_SPEED_MATCH),
                    nib(output_route_select_a, NIB_POS_DONE)};

    // ************************************************************
    // output pairs
    // ************************************************************
    logic [2:0] next_pair;

    genvar p;
    generate
        for (p = 0; p < NUM_PAIRS; p++) begin : g_pair
            ssr_route_mux #(
                .N    (N),
                .CODE (4'(p + 1))
            ) u_mux (
                .sig    (sig),
                .route  (route),
                .invert (output_pair_polarity[4*p]),   // see R5
                .level  (next_pair[p])
            );
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PAIR_OUT      <= 3'h0;
            FAULT_OUT     <= 1'b0;
            MOTION_DETECT <= 1'b0;
        end else begin
            PAIR_OUT      <= next_pair;   // see R14
            FAULT_OUT     <= ~ERROR;      // see R9
            MOTION_DETECT <= next_motion; // see R11
        end
    end

endmodule : ssr_router

// ### rtl/ssr_pkg.sv
// package of the servo status output router: register offsets, field positions, reset values
// assumes one drive clock; registers reached over a plain address/strobe port
package ssr_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [15:0] OFS_ROTARY_LEVEL   = 16'h2502;
    localparam logic [15:0] OFS_ROUTE_A        = 16'h250e;
    localparam logic [15:0] OFS_ROUTE_B        = 16'h250f;
    localparam logic [15:0] OFS_ROUTE_C        = 16'h2510;
    localparam logic [15:0] OFS_POLARITY       = 16'h2512;
    localparam logic [15:0] OFS_ROUTE_D        = 16'h2514;
    localparam logic [15:0] OFS_LINEAR_LEVEL   = 16'h2581;
    localparam logic [15:0] OFS_STATUS         = 16'h2600;
    localparam logic [15:0] OFS_MOTOR_SEL      = 16'h2601;

    // ************************************************************
    // reset values and ranges
    // ************************************************************
    localparam logic [15:0] RST_LEVEL          = 16'h0014;
    localparam logic [15:0] RST_ROUTE          = 16'h0000;
    localparam logic [15:0] RST_POLARITY       = 16'h0000;
    localparam logic [15:0] LEVEL_MIN          = 16'h0001;
    localparam logic [15:0] LEVEL_MAX          = 16'h2710;

    // ************************************************************
    // field positions (nibble index)
    // ************************************************************
    localparam int NIB_POS_DONE    = 0;
    localparam int NIB_SPEED_MATCH = 1;
    localparam int NIB_MOTION      = 2;
    localparam int NIB_READY       = 3;
    localparam int NIB_TORQUE_LIM  = 0;
    localparam int NIB_SPEED_LIM   = 1;
    localparam int NIB_BRAKE       = 2;
    localparam int NIB_WARNING     = 3;
    localparam int NIB_NEAR        = 0;
    localparam int NIB_MAINT       = 1;
    localparam int NUM_PAIRS       = 3;
    localparam int NUM_SIGNALS     = 10;

    // allocation codes
    typedef enum logic [3:0] {
        ROUTE_OFF   = 4'h0,
        ROUTE_PAIR1 = 4'h1,
        ROUTE_PAIR2 = 4'h2,
        ROUTE_PAIR3 = 4'h3
    } ssr_route_t;

    // control mode
    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_SPEED    = 2'b01,
        MODE_TORQUE   = 2'b10
    } ssr_mode_t;

endpackage : ssr_pkg

// ### rtl/ssr_route_mux.sv
// one output pair: OR of all signals routed to it, then polarity
// assumes signal and route nibbles are already qualified by the caller
`timescale 1ns/10ps
module ssr_route_mux #(
    parameter int          N    = ssr_pkg::NUM_SIGNALS,
    parameter logic [3:0]  CODE = 4'h1
) (
    input  wire logic [N-1:0]   sig,     // qualified status signals
    input  wire logic [4*N-1:0] route,   // allocation nibbles, one per signal
    input  wire logic           invert,  // pair polarity
    output      logic           level    // combined level
);
    import ssr_pkg::*;

    logic [N-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_sel
            assign hit[i] = sig[i] & (route[4*i +: 4] == CODE);   // see R1
        end
    endgenerate

    // inversion after the OR so a pair has one polarity
    assign level = (|hit) ^ invert;   // see R3 see R14

endmodule : ssr_route_mux

// ### rtl/ssr_speed_detect.sv
// motion detection: speed magnitude against selected level
// assumes speed is an unsigned magnitude in the motor's own unit
`timescale 1ns/10ps
module ssr_speed_detect #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] speed,        // motor speed magnitude
    input  wire logic [W-1:0] rotary_level, // rotary threshold, rpm
    input  wire logic [W-1:0] linear_level, // linear threshold, mm/s
    input  wire logic         linear,       // linear motor fitted
    output      logic         moving        // at or above level
);
    logic [W-1:0] level;

    assign level  = linear ? linear_level : rotary_level;   // see R11
    assign moving = (speed >= level);                       // see R11

endmodule : ssr_speed_detect

// ### tb/ssr_relay_model.sv
// relay contacts at the three terminal pairs and at the fault output
// assumes levels sampled on the drive clock; 1 = contact closed
`timescale 1ns/10ps
module ssr_relay_model (
    input  wire logic       clk,         // drive clock
    input  wire logic [2:0] pair_level,  // pair drive levels
    input  wire logic       fault_level, // fault output level
    output      logic [2:0] contact,     // contact closed per pair
    output      logic       alarm_open   // fault contact open
);
    // one clock of contact lag, as a relay never follows within the cycle
    always_ff @(posedge clk) begin
        contact    <= pair_level;
        alarm_open <= !fault_level;
    end
endmodule : ssr_relay_model

// ### tb/ssr_router_chk.sv
// checker of the status router: level register shadow and port assertions
// assumes it is bound into ssr_router and sees only its ports
`timescale 1ns/10ps
module ssr_router_chk #(
    parameter int SPEED_W = 16
) (
    input wire logic               CLK,           // drive clock
    input wire logic               NRST,          // sync reset, low active
    input wire logic [15:0]        ADDR,          // register address
    input wire logic [15:0]        WDATA,         // write data
    input wire logic               WR,            // write strobe
    input wire logic               RD,            // read strobe
    input wire logic [15:0]        RDATA,         // read data
    input wire logic               LINEAR_MOTOR,  // linear motor fitted
    input wire logic [SPEED_W-1:0] SPEED,         // motor speed
    input wire logic               ERROR,         // error detected
    input wire logic [2:0]         PAIR_OUT,      // terminal pairs
    input wire logic               FAULT_OUT,     // fault output
    input wire logic               MOTION_DETECT  // motion state
);
    import ssr_pkg::*;
    // ****
    // level shadow, clamped like the design
    // ****
    logic [15:0] lvl_rot;
    logic [15:0] lvl_lin;
    wire  logic [15:0] next_lvl = (WDATA < LEVEL_MIN) ? LEVEL_MIN : (WDATA > LEVEL_MAX) ? LEVEL_MAX : WDATA;
    wire  logic [15:0] sel_lvl  = LINEAR_MOTOR ? lvl_lin : lvl_rot;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            lvl_rot <= RST_LEVEL;
            lvl_lin <= RST_LEVEL;
        end else if (WR && ADDR == OFS_ROTARY_LEVEL) begin
            lvl_rot <= next_lvl;
        end else if (WR && ADDR == OFS_LINEAR_LEVEL) begin
            lvl_lin <= next_lvl;
        end
    end
    // ****
    // assertions
    // ****
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_fault; $past(NRST) |-> FAULT_OUT == !$past(ERROR); endproperty
    property p_reset; !$past(NRST) |-> PAIR_OUT == 3'h0 && !FAULT_OUT && !MOTION_DETECT; endproperty
    property p_rd_idle; $past(NRST) && !$past(RD) |-> RDATA == 16'h0; endproperty
    property p_rot_read; RD && ADDR == OFS_ROTARY_LEVEL |=> RDATA == $past(lvl_rot); endproperty
    property p_lin_read; RD && ADDR == OFS_LINEAR_LEVEL |=> RDATA == $past(lvl_lin); endproperty
    property p_motion; $past(NRST) |-> MOTION_DETECT == ($past(SPEED) >= $past(sel_lvl)); endproperty
    property p_unmapped; RD && ADDR == 16'h2000 |=> RDATA == 16'h0; endproperty
    property p_pol_read; RD && ADDR == OFS_POLARITY |=> RDATA[15:12] == 4'h0; endproperty
    a_fault: assert property (p_fault) else $error("fault output not inverse of error");
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    a_rot_read: assert property (p_rot_read) else $error("rotary level readback wrong");
    a_lin_read: assert property (p_lin_read) else $error("linear level readback wrong");
    a_motion: assert property (p_motion) else $error("motion state wrong for speed");
    a_unmapped: assert property (p_unmapped) else $error("unmapped address not zero");
    a_pol_read: assert property (p_pol_read) else $error("polarity upper bits not zero");
    c_motion: cover property ($rose(MOTION_DETECT));
    c_fault: cover property ($fell(FAULT_OUT));
    c_all_pairs: cover property (PAIR_OUT == 3'h7);
endmodule : ssr_router_chk

bind ssr_router ssr_router_chk #(.SPEED_W(SPEED_W)) u_ssr_router_chk (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINEAR_MOTOR(LINEAR_MOTOR), .SPEED(SPEED),
    .ERROR(ERROR), .PAIR_OUT(PAIR_OUT), .FAULT_OUT(FAULT_OUT), .MOTION_DETECT(MOTION_DETECT));

// ### tb/tb_top.sv
// testbench of the status router: register tasks and routing scenarios
// assumes the relay model as far side; contacts lag the pairs by one clock
`timescale 1ns/10ps
module tb_top;
    import ssr_pkg::*;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0, lin = 0, error = 0;
    logic [15:0] addr = 0, wdata = 0, speed = 0;
    logic [8:0]  sig = 0;
    ssr_mode_t   mode = MODE_POSITION;
    wire  [15:0] rdata;
    wire  [2:0]  pair, contact;
    wire         fault, motion, alarm_open;
    int          error_cnt = 0, comparisons = 0;
    logic [15:0] ra [9] = '{OFS_ROUTE_A, OFS_ROUTE_A, OFS_ROUTE_A, OFS_ROUTE_B, OFS_ROUTE_B,
                            OFS_ROUTE_B, OFS_ROUTE_B, OFS_ROUTE_C, OFS_ROUTE_D};
    int          nb [9] = '{0, 1, 3, 0, 1, 2, 3, 0, 1};
    always #2 clk = ~clk;
    ssr_router u_ssr_router (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MODE(mode), .LINEAR_MOTOR(lin), .SPEED(speed), .POS_DONE(sig[0]),
        .SPEED_MATCH(sig[1]), .SERVO_READY(sig[2]), .TORQUE_LIMITED(sig[3]), .SPEED_LIMITED(sig[4]),
        .BRAKE_RELEASE(sig[5]), .WARNING(sig[6]), .NEAR_POS(sig[7]), .MAINT_DUE(sig[8]),
        .ERROR(error), .PAIR_OUT(pair), .FAULT_OUT(fault), .MOTION_DETECT(motion));
    ssr_relay_model u_ssr_relay_model (.clk(clk), .pair_level(pair), .fault_level(fault),
        .contact(contact), .alarm_open(alarm_open));
    // ****
    // tasks
    // ****
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask : reg_wr
    task reg_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1; addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, exp);
    endtask : reg_rd
    task see(input logic [2:0] exp);
        repeat (3) @(posedge clk);
        #1 chk({13'h0, contact}, {13'h0, exp});
    endtask : see
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #40000;
        error_cnt++;
        print_verdict;
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1;
        reg_rd(OFS_ROTARY_LEVEL, RST_LEVEL);
        reg_rd(OFS_LINEAR_LEVEL, RST_LEVEL);
        reg_rd(OFS_ROUTE_A, RST_ROUTE);
        reg_rd(16'h2000, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            reg_wr(ra[i], 16'h2 << (4 * nb[i]));
            @(posedge clk) sig <= 9'h1 << i;
            mode <= (i == 1) ? MODE_SPEED : MODE_POSITION;
            see(3'b010);
            reg_rd(ra[i], 16'h2 << (4 * nb[i]));
            reg_wr(ra[i], 16'h0000);
            see(3'b000);
        end
        @(posedge clk) sig <= 9'h001;
        mode <= MODE_POSITION;
        for (int c = 1; c < 4; c++) begin
            reg_wr(OFS_ROUTE_A, 16'(c));
            see(3'h1 << (c - 1));
        end
        @(posedge clk) mode <= MODE_SPEED;
        see(3'b000);
        @(posedge clk) mode <= MODE_TORQUE;
        see(3'b000);
        $display("test routing done");
        reg_wr(OFS_ROUTE_A, 16'h1000);
        reg_wr(OFS_ROUTE_B, 16'h0100);
        @(posedge clk) sig <= 9'h024;
        see(3'b001);
        @(posedge clk) sig <= 9'h000;
        see(3'b000);
        reg_wr(OFS_POLARITY, 16'hf111);
        see(3'b111);
        reg_rd(OFS_POLARITY, 16'h0111);
        @(posedge clk) sig <= 9'h020;
        see(3'b110);
        reg_wr(OFS_POLARITY, 16'h0000);
        $display("test or polarity done");
        reg_wr(OFS_ROUTE_B, 16'h0000);
        reg_wr(OFS_ROUTE_A, 16'h0300);
        @(posedge clk) speed <= 16'h0014;
        see(3'b100);
        @(posedge clk) speed <= 16'h0013;
        see(3'b000);
        reg_wr(OFS_LINEAR_LEVEL, 16'h0064);
        @(posedge clk) lin <= 1;
        speed <= 16'h0063;
        see(3'b000);
        @(posedge clk) speed <= 16'h0064;
        see(3'b100);
        reg_wr(OFS_ROTARY_LEVEL, 16'h0000);
        reg_rd(OFS_ROTARY_LEVEL, 16'h0001);
        reg_wr(OFS_ROTARY_LEVEL, 16'hffff);
        reg_rd(OFS_ROTARY_LEVEL, 16'h2710);
        $display("test motion done");
        @(posedge clk) error <= 1;
        see(3'b100);
        chk({15'h0, alarm_open}, 16'h0001);
        @(posedge clk) error <= 0;
        see(3'b100);
        chk({15'h0, fault}, 16'h0001);
        chk({15'h0, motion}, 16'h0001);
        // status word: motion bit 5, fault bit 4, pairs bits 2..0
        reg_rd(OFS_STATUS, 16'h0034);
        $display("test fault done");
        // mid-run reset must drop routes and levels back to defaults
        @(posedge clk) nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        reg_rd(OFS_ROTARY_LEVEL, RST_LEVEL);
        reg_rd(OFS_ROUTE_A, RST_ROUTE);
        see(3'b000);
        $display("test reset again done");
        print_verdict;
    end
endmodule : tb_top
